/* File: hw/nexus_pkg.sv */
/*
 * Shared constants for the backplane nexus pair: function codes, format tags,
 * confirmation codes and cycle counts.
 * Assumes a 40 MHz system clock and a backplane clock divided down from it.
 */
package nexus_pkg;
    // function codes carried in the top nibble of the command/address word
    localparam logic [3:0] FN_READ = 4'h1;
    localparam logic [3:0] FN_WRITE = 4'h2;
    localparam logic [3:0] FN_IL_READ = 4'h4;
    localparam logic [3:0] FN_IL_WRITE = 4'h7;
    localparam logic [3:0] FN_EXT_WRITE = 4'hb;
    // format tags
    localparam logic [2:0] TAG_RDATA = 3'h0;
    localparam logic [2:0] TAG_CA = 3'h3;
    localparam logic [2:0] TAG_WDATA = 3'h5;
    localparam logic [2:0] TAG_IDLE = 3'h7;
    // confirmation codes
    localparam logic [1:0] CONF_NONE = 2'h0;
    localparam logic [1:0] CONF_ACK = 2'h1;
    localparam logic [1:0] CONF_ERR = 2'h2;
    localparam logic [1:0] CONF_BUSY = 2'h3;
    // clocking
    localparam int CLK_PERIOD_NS = 25;
    localparam int BUS_PERIOD_NS = 125;
    localparam logic [2:0] DIV_LAST = 3'(BUS_PERIOD_NS / CLK_PERIOD_NS - 1);
    localparam logic [2:0] DIV_HIGH = 3'h2;
    localparam logic [2:0] DIV_TICK = 3'h3;
    // interlock timeout, longest time so rounded down
    localparam int IL_TIMEOUT_NS = 102400;
    localparam logic [9:0] IL_TIMEOUT_CYC = 10'(IL_TIMEOUT_NS / BUS_PERIOD_NS);
    localparam logic [4:0] RESTORE_MIN_CYC = 5'h0f;
    localparam logic [2:0] READ_DELAY_CYC = 3'h3;
    localparam logic [4:0] READ_WAIT_CYC = 5'h18;
    // responder decode: 16 longwords at this block of the address space
    localparam int MEM_WORDS = 16;
    localparam logic [23:0] DEV_BASE = 24'h000000;
    // link-side reset stretch, one bit per system cycle after release
    localparam logic [15:0] LINK_RST_FILL = 16'hffff;
endpackage : nexus_pkg

/* File: hw/nexus_link_if.sv */
/*
 * Backplane link between a commander nexus and a responder nexus.
 * The commander makes bus_clk; the bench drives clock_loss, and each
 * of the other lines is driven from one end only.
 */
`timescale 1ns/1ps
`default_nettype none
interface nexus_link_if;
    logic bus_clk;
    logic [2:0] cmd_tag;
    logic [3:0] cmd_mask;
    logic [31:0] cmd_info;
    logic bus_hold_line;
    logic restore;
    logic [1:0] conf;
    logic interlock;
    logic rsp_valid;
    logic [2:0] rsp_tag;
    logic [3:0] rsp_mask;
    logic [31:0] rsp_data;
    logic fault;
    logic fail;
    logic clock_loss;

    modport commander (
        output bus_clk, cmd_tag, cmd_mask, cmd_info, bus_hold_line, restore,
        input conf, interlock, rsp_valid, rsp_tag, rsp_mask, rsp_data, fault, fail,
        input clock_loss
    );
    modport responder (
        input bus_clk, cmd_tag, cmd_mask, cmd_info, bus_hold_line, restore,
        output conf, interlock, rsp_valid, rsp_tag, rsp_mask, rsp_data, fault, fail,
        input clock_loss
    );
endinterface : nexus_link_if
`default_nettype wire

/* File: hw/nexus_commander.sv */
/*
 * Commander end: divides CLK_I down to the backplane clock, issues reads,
 * writes, extended writes, interlock pairs and the restore sequence.
 * Assumes the requester holds REQ_* stable while REQ_VALID_I is high.
 */
`timescale 1ns/1ps
`default_nettype none
module nexus_commander (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    nexus_link_if.commander L,
    input wire logic REQ_VALID_I,
    output logic REQ_READY_O,
    input wire logic [3:0] REQ_FUNC_I,
    input wire logic [27:0] REQ_ADDR_I,
    input wire logic [3:0] REQ_MASK_I,
    input wire logic [31:0] REQ_DATA_I,
    input wire logic [3:0] REQ_MASK2_I,
    input wire logic [31:0] REQ_DATA2_I,
    input wire logic RESTORE_I,
    output logic RSP_VALID_O,
    output logic [1:0] RSP_STATUS_O,
    output logic [31:0] RSP_DATA_O,
    output logic IL_HELD_O
);
    typedef enum logic [3:0] {
        C_IDLE = 4'b0001, C_PEND = 4'b0010, C_RUN = 4'b0100, C_RST = 4'b1000
    } cst_t;
    cst_t st_q;
    logic [2:0] div_q;
    logic lclk_q, tick;
    logic [1:0] conf_s1, conf_s2;
    logic rv_s1, rv_s2, dead_s1, dead_s2;
    logic [2:0] rtag_s1, rtag_s2;
    logic [31:0] rdat_s1, rdat_s2;
    logic [3:0] fn_q, m_q, m2_q;
    logic [27:0] a_q;
    logic [31:0] d_q, d2_q;
    logic [4:0] step_q;
    logic [1:0] rph_q;
    logic [2:0] tag_q;
    logic [3:0] mask_q;
    logic [31:0] info_q;
    logic hold_q, rest_q;
    logic is_wr, is_ext;

    assign L.bus_clk = lclk_q;
    assign L.cmd_tag = tag_q;
    assign L.cmd_mask = mask_q;
    assign L.cmd_info = info_q;
    assign L.bus_hold_line = hold_q;
    assign L.restore = rest_q;
    assign tick = (div_q == nexus_pkg::DIV_TICK);
    assign is_wr = (fn_q == nexus_pkg::FN_WRITE) || (fn_q == nexus_pkg::FN_IL_WRITE) || is_ext;
    assign is_ext = (fn_q == nexus_pkg::FN_EXT_WRITE);

    // link clock high for the first two of five system cycles
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            div_q <= 3'h0;
            lclk_q <= 1'b0;
        end else begin
            div_q <= (div_q == nexus_pkg::DIV_LAST) ? 3'h0 : div_q + 3'h1;
            lclk_q <= (div_q == nexus_pkg::DIV_LAST) || (div_q < nexus_pkg::DIV_HIGH - 3'h1);
        end
    end

    // responder lines settle after the rising edge; read mid-cycle
    always_ff @(posedge CLK_I) begin
        conf_s1 <= L.conf;
        conf_s2 <= conf_s1;
        rv_s1 <= L.rsp_valid;
        rv_s2 <= rv_s1;
        rtag_s1 <= L.rsp_tag;
        rtag_s2 <= rtag_s1;
        rdat_s1 <= L.rsp_data;
        rdat_s2 <= rdat_s1;
        dead_s1 <= L.clock_loss;
        dead_s2 <= dead_s1;
    end

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            st_q <= C_IDLE;
            REQ_READY_O <= 1'b1;
            RSP_VALID_O <= 1'b0;
            RSP_STATUS_O <= nexus_pkg::CONF_NONE;
            RSP_DATA_O <= 32'h0;
            IL_HELD_O <= 1'b0;
            step_q <= 5'h0;
            rph_q <= 2'h0;
            tag_q <= nexus_pkg::TAG_IDLE;
            mask_q <= 4'h0;
            info_q <= 32'h0;
            hold_q <= 1'b0;
            rest_q <= 1'b0;
            fn_q <= 4'h0;
            a_q <= 28'h0;
            m_q <= 4'h0;
            m2_q <= 4'h0;
            d_q <= 32'h0;
            d2_q <= 32'h0;
        end else begin
            RSP_VALID_O <= 1'b0;
            unique case (st_q)
                C_IDLE: begin
                    if (RESTORE_I) begin
                        st_q <= C_RST;
                        REQ_READY_O <= 1'b0;
                        rph_q <= 2'h0;
                        step_q <= 5'h0;
                    end else if (REQ_VALID_I && REQ_READY_O) begin
                        REQ_READY_O <= 1'b0;
                        if (IL_HELD_O && REQ_FUNC_I != nexus_pkg::FN_IL_WRITE) begin
                            RSP_VALID_O <= 1'b1;
                            RSP_STATUS_O <= nexus_pkg::CONF_ERR;
                            REQ_READY_O <= 1'b1;
                        end else begin
                            st_q <= C_PEND;
                            fn_q <= REQ_FUNC_I;
                            a_q <= REQ_ADDR_I;
                            m_q <= REQ_MASK_I;
                            m2_q <= REQ_MASK2_I;
                            d_q <= REQ_DATA_I;
                            d2_q <= REQ_DATA2_I;
                        end
                    end
                end
                C_PEND: begin
                    if (tick && !dead_s2) begin
                        tag_q <= nexus_pkg::TAG_CA;
                        info_q <= {fn_q, a_q};
                        mask_q <= is_ext ? m_q : (is_wr || fn_q == nexus_pkg::FN_READ
                                  || fn_q == nexus_pkg::FN_IL_READ ? m_q : 4'h0);
                        hold_q <= is_wr;
                        step_q <= 5'h0;
                        st_q <= C_RUN;
                    end
                end
                C_RUN: begin
                    if (tick) begin
                        step_q <= step_q + 5'h1;
                        tag_q <= nexus_pkg::TAG_IDLE;
                        mask_q <= 4'h0;
                        hold_q <= 1'b0;
                        if (step_q == 5'h0 && is_wr && !dead_s2) begin
                            tag_q <= nexus_pkg::TAG_WDATA;
                            info_q <= d_q;
                            mask_q <= is_ext ? m2_q : 4'h0;
                            hold_q <= is_ext;
                        end
                        if (step_q == 5'h1 && is_ext && !dead_s2) begin
                            tag_q <= nexus_pkg::TAG_WDATA;
                            info_q <= d2_q;
                        end
                        // address-word confirmation is seen one tick after the first data
                        if (step_q == 5'h1 && conf_s2 != nexus_pkg::CONF_ACK) begin
                            st_q <= C_IDLE;
                            REQ_READY_O <= 1'b1;
                            RSP_VALID_O <= 1'b1;
                            RSP_STATUS_O <= (conf_s2 == nexus_pkg::CONF_BUSY) ?
                                            nexus_pkg::CONF_BUSY : nexus_pkg::CONF_ERR;
                        end else if (is_wr && step_q == (is_ext ? 5'h3 : 5'h2)) begin
                            st_q <= C_IDLE;
                            REQ_READY_O <= 1'b1;
                            RSP_VALID_O <= 1'b1;
                            RSP_STATUS_O <= (conf_s2 == nexus_pkg::CONF_ACK) ?
                                            nexus_pkg::CONF_ACK : nexus_pkg::CONF_ERR;
                            if (fn_q == nexus_pkg::FN_IL_WRITE) begin
                                IL_HELD_O <= 1'b0;
                            end
                        end else if (!is_wr && step_q > 5'h2 &&
                                     ((rv_s2 && rtag_s2 == nexus_pkg::TAG_RDATA) ||
                                      step_q == nexus_pkg::READ_WAIT_CYC)) begin
                            st_q <= C_IDLE;
                            REQ_READY_O <= 1'b1;
                            RSP_VALID_O <= 1'b1;
                            RSP_DATA_O <= rdat_s2;
                            RSP_STATUS_O <= rv_s2 ? nexus_pkg::CONF_ACK : nexus_pkg::CONF_ERR;
                            IL_HELD_O <= rv_s2 && (fn_q == nexus_pkg::FN_IL_READ);
                        end
                    end
                end
                C_RST: begin
                    // pulse length, ends at cycle start
                    if (tick) begin
                        hold_q <= (rph_q != 2'h3) && !dead_s2;
                        rest_q <= (rph_q == 2'h1) && !dead_s2;
                        tag_q <= nexus_pkg::TAG_IDLE;
                        step_q <= step_q + 5'h1;
                        if (step_q == nexus_pkg::RESTORE_MIN_CYC) begin
                            step_q <= 5'h0;
                            rph_q <= rph_q + 2'h1;
                            if (rph_q == 2'h3) begin
                                st_q <= C_IDLE;
                                REQ_READY_O <= 1'b1;
                                IL_HELD_O <= 1'b0;
                            end
                        end
                    end
                end
            endcase
        end
    end
endmodule : nexus_commander
`default_nettype wire

/* File: hw/nexus_responder.sv */
/*
 * Responder end: decodes commands on the backplane, stores masked and
 * extended writes in a small longword store, returns read data, keeps the
 * interlock flip-flop with its timeout, and obeys clock-loss, power-fail and
 * restore. Link logic runs on bus_clk, except the power-fail line; the user side runs on CLK_I.
 * Assumes the commander keeps its own duties (hold line, pairing, restore).
 */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - function 1011 always uses two data cycles; responder goes idle after one if the first is not tagged write data
// - commander sends address word, holds bus
// - address-word mask picks first longword bytes
// - commander tags data, holds through first
// - first data mask picks second; second ignored
// - acknowledge address word with second longword
// - acknowledge each data cycle, in order
// - interlock read reads and sets flip-flop
// - drive interlock line from acknowledge cycle
// - busy answer to interlock read while held
// - interlock write data clears the flip-flop
// - clear flip-flop after timeout expires
// - without interlock, treat as plain commands
// - commander pairs every interlock read/write
// - interlock pair maps to pause/write sequence
// - drive nothing during clock-loss warning; read data still goes out on rsp_data
// - hold power-fail while AC power low
// - restore pulse long enough, ends at T0
// - hold line wraps restore both sides
// - restore: no operations, idle at end
// - no new fault during restore
// - restore cancels reads, keeps stored data
module nexus_responder #(
    parameter bit INTERLOCK_EN = 1'b1
) (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    nexus_link_if.responder L,
    input wire logic AC_LOW_I,
    output logic WR_STB_O,
    output logic [27:0] WR_ADDR_O,
    output logic [3:0] WR_BE_O,
    output logic [31:0] WR_DATA_O,
    output logic PAUSE_HELD_O,
    output logic RESTORE_O
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001, ST_WD1 = 3'b010, ST_WD2 = 3'b100
    } rst_t;
    rst_t st_q;
    logic lr_s1, lr_s2, dd_s1, dd_s2;
    logic lrst, dead;
    logic [3:0] fn, op_q, msk_q, msk2_q, wr_be;
    logic [27:0] adr_q;
    logic [3:0] wr_idx;
    logic [31:0] mem [nexus_pkg::MEM_WORDS];
    logic [15:0] link_rst_q;
    logic ca_take, is_rd, il_rd, busy, wd_now, wd_ok, wr_now, known;
    logic [1:0] pend_q;
    logic il_q;
    logic [9:0] il_cnt_q;
    logic rd_pend_q;
    logic [2:0] rd_cnt_q;
    logic [3:0] rd_adr_q;
    logic fault_q;
    logic [1:0] conf_q;
    logic il_line_q, rv_q, fault_line_q;
    logic [31:0] rdat_q;
    logic wr_tgl_q;
    logic [27:0] wa_q;
    logic [3:0] wb_q;
    logic [31:0] wd_q;
    logic t_s1, t_s2, t_s3, ac_s1, ac_s2, il_s1, il_s2, rs_s1, rs_s2, fail_q;

    assign L.conf = conf_q;
    assign L.interlock = il_line_q;
    assign L.rsp_valid = rv_q;
    assign L.rsp_tag = nexus_pkg::TAG_RDATA;
    assign L.rsp_mask = 4'h0;
    assign L.rsp_data = rdat_q;
    assign L.fault = fault_line_q;
    assign L.fail = fail_q;

    // bus_clk is stopped while RSTN_I is low, so stretch reset past release
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            link_rst_q <= nexus_pkg::LINK_RST_FILL;
        end else begin
            link_rst_q <= {link_rst_q[14:0], 1'b0};
        end
    end

    // link-domain reset and clock-loss warning
    always_ff @(posedge L.bus_clk) begin
        lr_s1 <= link_rst_q[15];
        lr_s2 <= lr_s1;
        dd_s1 <= L.clock_loss;
        dd_s2 <= dd_s1;
    end
    assign lrst = lr_s2;
    assign dead = dd_s2;

    // command decode on the latched lines (T3 of each cycle)
    assign fn = L.cmd_info[31:28];
    // interlock codes fold into plain ones
    assign il_rd = INTERLOCK_EN && (fn == nexus_pkg::FN_IL_READ);
    assign is_rd = (fn == nexus_pkg::FN_READ) || (fn == nexus_pkg::FN_IL_READ);
    assign known = is_rd || fn == nexus_pkg::FN_WRITE || fn == nexus_pkg::FN_IL_WRITE
                   || fn == nexus_pkg::FN_EXT_WRITE;
    assign busy = il_rd && il_q;
    assign ca_take = (st_q == ST_IDLE) && !L.restore && !dead && known
                     && (L.cmd_tag == nexus_pkg::TAG_CA)
                     && (L.cmd_info[27:4] == nexus_pkg::DEV_BASE);
    assign wd_now = (st_q != ST_IDLE) && !L.restore;
    assign wd_ok = (L.cmd_tag == nexus_pkg::TAG_WDATA);
    assign wr_now = wd_now && wd_ok;

    always_comb begin
        wr_idx = adr_q[3:0];
        wr_be = msk_q;
        if (op_q == nexus_pkg::FN_EXT_WRITE) begin
            wr_idx = {adr_q[3:1], st_q == ST_WD2};
            wr_be = (st_q == ST_WD2) ? msk2_q : msk_q;
        end
    end

    // extended write takes two data cycles unless its first data cycle is not tagged as write data
    always_ff @(posedge L.bus_clk) begin
        if (lrst || L.restore) begin
            st_q <= ST_IDLE;
            op_q <= 4'h0;
            adr_q <= 28'h0;
            msk_q <= 4'h0;
            msk2_q <= 4'h0;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    if (ca_take && !is_rd) begin
                        st_q <= ST_WD1;
                        op_q <= fn;
                        adr_q <= L.cmd_info[27:0];
                        msk_q <= L.cmd_mask;
                    end
                end
                ST_WD1: begin
                    msk2_q <= L.cmd_mask;
                    st_q <= (wd_ok && op_q == nexus_pkg::FN_EXT_WRITE) ? ST_WD2 : ST_IDLE;
                end
                ST_WD2: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // each transfer is confirmed two cycles after it
    // address ack lands with second longword
    // data acks follow one per cycle
    always_ff @(posedge L.bus_clk) begin
        if (lrst || L.restore) begin
            pend_q <= nexus_pkg::CONF_NONE;
            conf_q <= nexus_pkg::CONF_NONE;
        end else begin
            if (ca_take) begin
                pend_q <= busy ? nexus_pkg::CONF_BUSY : nexus_pkg::CONF_ACK;
            end else if (wd_now) begin
                pend_q <= wd_ok ? nexus_pkg::CONF_ACK : nexus_pkg::CONF_NONE;
            end else begin
                pend_q <= nexus_pkg::CONF_NONE;
            end
            // bad first data withholds the address acknowledge
            // silent under clock-loss warning
            if (dead || (st_q == ST_WD1 && !wd_ok)) begin
                conf_q <= nexus_pkg::CONF_NONE;
            end else begin
                conf_q <= pend_q;
            end
        end
    end

    // store keeps its contents across restore
    always_ff @(posedge L.bus_clk) begin
        if (wr_now) begin
            for (int b = 0; b < 4; b++) begin
                if (wr_be[b]) begin
                    mem[wr_idx][8*b +: 8] <= L.cmd_info[8*b +: 8];
                end
            end
        end
    end

    // interlock flip-flop and its timeout
    always_ff @(posedge L.bus_clk) begin
        if (lrst || L.restore) begin
            il_q <= 1'b0;
            il_cnt_q <= 10'h0;
        end else if (il_q && il_cnt_q == nexus_pkg::IL_TIMEOUT_CYC) begin
            il_q <= 1'b0;
            il_cnt_q <= 10'h0;
        end else if (INTERLOCK_EN && wr_now && op_q == nexus_pkg::FN_IL_WRITE) begin
            il_q <= 1'b0;
            il_cnt_q <= 10'h0;
        end else if (ca_take && il_rd && !busy) begin
            il_q <= 1'b1;
            il_cnt_q <= 10'h0;
        end else if (il_q) begin
            il_cnt_q <= il_cnt_q + 10'h1;
        end
    end

    // read return, a fixed delay after the address word
    always_ff @(posedge L.bus_clk) begin
        if (lrst || L.restore) begin
            rd_pend_q <= 1'b0;
            rd_cnt_q <= 3'h0;
            rd_adr_q <= 4'h0;
        // interlock read returns data like plain
        end else if (ca_take && is_rd && !busy) begin
            rd_pend_q <= 1'b1;
            rd_cnt_q <= nexus_pkg::READ_DELAY_CYC;
            rd_adr_q <= L.cmd_info[3:0];
        end else if (rd_pend_q) begin
            rd_cnt_q <= rd_cnt_q - 3'h1;
            rd_pend_q <= (rd_cnt_q != 3'h0);
        end
    end

    // line drivers; all but the read data dropped while the clock-loss warning stands
    always_ff @(posedge L.bus_clk) begin
        if (lrst) begin
            il_line_q <= 1'b0;
            rv_q <= 1'b0;
            rdat_q <= 32'h0;
            fault_q <= 1'b0;
            fault_line_q <= 1'b0;
        end else begin
            // line follows flip-flop from ack cycle
            il_line_q <= il_q && !dead;
            rv_q <= rd_pend_q && rd_cnt_q == 3'h0 && !dead && !L.restore;
            rdat_q <= (rd_pend_q && rd_cnt_q == 3'h0) ? mem[rd_adr_q] : 32'h0;
            // held fault stays, no new one in restore
            if (wd_now && !wd_ok && !L.restore) begin
                fault_q <= 1'b1;
            end
            fault_line_q <= (fault_q || (wd_now && !wd_ok && !L.restore)) && !dead;
        end
    end

    // write report for the user side, handed over by toggle
    always_ff @(posedge L.bus_clk) begin
        if (lrst) begin
            wr_tgl_q <= 1'b0;
            wa_q <= 28'h0;
            wb_q <= 4'h0;
            wd_q <= 32'h0;
        end else if (wr_now) begin
            wr_tgl_q <= !wr_tgl_q;
            wa_q <= {adr_q[27:4], wr_idx};
            wb_q <= wr_be;
            wd_q <= L.cmd_info;
        end
    end

    // user side; report fields stay still a full bus cycle, longer than the sync
    always_ff @(posedge CLK_I) begin
        t_s1 <= wr_tgl_q;
        t_s2 <= t_s1;
        il_s1 <= il_q;
        il_s2 <= il_s1;
        rs_s1 <= L.restore;
        rs_s2 <= rs_s1;
        ac_s1 <= AC_LOW_I;
        ac_s2 <= ac_s1;
    end

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            t_s3 <= 1'b0;
            WR_STB_O <= 1'b0;
            WR_ADDR_O <= 28'h0;
            WR_BE_O <= 4'h0;
            WR_DATA_O <= 32'h0;
            PAUSE_HELD_O <= 1'b0;
            RESTORE_O <= 1'b0;
            fail_q <= 1'b0;
        end else begin
            t_s3 <= t_s2;
            // write report ends the pause/write pair
            WR_STB_O <= t_s2 ^ t_s3;
            if (t_s2 ^ t_s3) begin
                WR_ADDR_O <= wa_q;
                WR_BE_O <= wb_q;
                WR_DATA_O <= wd_q;
            end
            PAUSE_HELD_O <= il_s2;
            RESTORE_O <= rs_s2;
            // power-fail follows AC low, not the bus clock
            fail_q <= ac_s2;
        end
    end
endmodule : nexus_responder
`default_nettype wire

/* File: tb/nexus_link_chk.sv */
/* link rule checker on the bus_clk domain.
   expects the link lines as plain inputs and the system reset. */
`timescale 1ns/1ps
`default_nettype none
module nexus_link_chk (
    input wire logic bus_clk,
    input wire logic RSTN_I,
    input wire logic [2:0] cmd_tag,
    input wire logic [31:0] cmd_info,
    input wire logic bus_hold_line,
    input wire logic restore,
    input wire logic [1:0] conf,
    input wire logic interlock,
    input wire logic rsp_valid,
    input wire logic fault,
    input wire logic clock_loss
);
    // address word the responder will take
    wire logic ca = cmd_tag == 3'h3 && cmd_info[27:4] == 24'h0 && !restore && !clock_loss;
    wire logic [3:0] fn = cmd_info[31:28];
    default clocking @(posedge bus_clk); endclocking
    default disable iff (!RSTN_I);
    a_ext_acks: assert property (ca && fn == 4'hb |=> cmd_tag == 3'h5 ##1 conf == 2'h1
        ##1 conf == 2'h1 ##1 conf == 2'h1) else $error("extended write acks wrong");
    a_ext_hold: assert property (ca && fn == 4'hb |-> bus_hold_line ##1 bus_hold_line
        ##1 !bus_hold_line) else $error("hold line wrong in extended write");
    a_ilrd_line: assert property (ca && fn == 4'h4 && !interlock |-> ##2
        conf == 2'h1 && interlock ##3 rsp_valid) else $error("interlock read answer wrong");
    a_il_busy: assert property (ca && fn == 4'h4 && interlock |-> ##2 conf == 2'h3)
        else $error("no busy while interlocked");
    a_ilwr_clear: assert property (ca && fn == 4'h7 && interlock |-> ##[2:4] !interlock)
        else $error("interlock line not cleared");
    a_loss_quiet: assert property (clock_loss [*4] |-> conf == 2'h0 && !rsp_valid)
        else $error("driving during clock loss");
    a_restore_quiet: assert property (restore [*2] |-> conf == 2'h0 && !rsp_valid
        && !$rose(fault)) else $error("activity during restore");
    a_restore_len: assert property (restore ##1 !restore |-> $past(restore, 15) && bus_hold_line)
        else $error("restore pulse too short");
endmodule : nexus_link_chk
`default_nettype wire

/* File: tb/tb.sv */
/* bench: both nexus ends joined by one link.
   assumes the bench makes CLK_I, reset and the clock-loss line. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic CLK_I = 0, RSTN_I = 0, REQ_VALID_I = 0, RESTORE_I = 0, AC_LOW_I = 0;
    logic [3:0] REQ_FUNC_I = 0, REQ_MASK_I = 0, REQ_MASK2_I = 0, WR_BE_O;
    logic [27:0] REQ_ADDR_I = 0, WR_ADDR_O;
    logic [31:0] REQ_DATA_I = 0, REQ_DATA2_I = 0, RSP_DATA_O, WR_DATA_O;
    logic REQ_READY_O, RSP_VALID_O, IL_HELD_O, WR_STB_O, PAUSE_HELD_O, RESTORE_O;
    logic [1:0] RSP_STATUS_O;
    logic [63:0] wq[$];
    int fails = 0, comparisons = 0;
    nexus_link_if L();
    nexus_commander nexus_commander_i(.CLK_I, .RSTN_I, .L(L), .REQ_VALID_I, .REQ_READY_O,
        .REQ_FUNC_I, .REQ_ADDR_I, .REQ_MASK_I, .REQ_DATA_I, .REQ_MASK2_I, .REQ_DATA2_I,
        .RESTORE_I, .RSP_VALID_O, .RSP_STATUS_O, .RSP_DATA_O, .IL_HELD_O);
    nexus_responder nexus_responder_i(.CLK_I, .RSTN_I, .L(L), .AC_LOW_I, .WR_STB_O,
        .WR_ADDR_O, .WR_BE_O, .WR_DATA_O, .PAUSE_HELD_O, .RESTORE_O);
    nexus_link_chk nexus_link_chk_i(.bus_clk(L.bus_clk), .RSTN_I, .cmd_tag(L.cmd_tag),
        .cmd_info(L.cmd_info), .bus_hold_line(L.bus_hold_line), .restore(L.restore),
        .conf(L.conf), .interlock(L.interlock), .rsp_valid(L.rsp_valid),
        .fault(L.fault), .clock_loss(L.clock_loss));
    always #12.5 CLK_I = ~CLK_I;
    // negedge keeps the capture clear of the strobe's own edge
    always @(negedge CLK_I) if (WR_STB_O === 1'b1) wq.push_back({WR_ADDR_O, WR_BE_O, WR_DATA_O});
    task chk(input logic [71:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task test_done;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : test_done
    task automatic req(input logic [3:0] f, input logic [27:0] a, input logic [3:0] m,
        input logic [31:0] d, input logic [3:0] m2);
        int n;
        @(posedge CLK_I);
        {REQ_FUNC_I, REQ_ADDR_I, REQ_MASK_I, REQ_DATA_I, REQ_MASK2_I, REQ_DATA2_I,
            REQ_VALID_I} <= {f, a, m, d, m2, ~d, 1'b1};
        #1 for (n = 0; n < 500 && REQ_READY_O !== 1'b1; n++) @(posedge CLK_I) #1;
        @(posedge CLK_I) REQ_VALID_I <= 1'b0;
        #1 for (n = 0; n < 500 && RSP_VALID_O !== 1'b1; n++) @(posedge CLK_I) #1;
        if (n == 500) fails++;
    endtask : req
    initial begin
        L.clock_loss = 0;
        repeat (4) @(posedge CLK_I);
        RSTN_I <= 1;
        repeat (40) @(posedge CLK_I);
        req(nexus_pkg::FN_EXT_WRITE, 28'h2, 4'h3, 32'h11223344, 4'hc);
        chk(RSP_STATUS_O, 1);
        repeat (20) @(posedge CLK_I);
        chk(wq.size(), 2);
        chk(wq[0], {28'h2, 4'h3, 32'h11223344});
        chk(wq[1], {28'h3, 4'hc, 32'heeddccbb});
        req(nexus_pkg::FN_IL_READ, 28'h2, 4'hf, 0, 0);
        chk(RSP_DATA_O[15:0], 16'h3344);
        chk({RSP_STATUS_O, IL_HELD_O, PAUSE_HELD_O}, 4'h7);
        req(nexus_pkg::FN_READ, 28'h3, 4'hf, 0, 0);
        chk(RSP_STATUS_O, 2);
        wq.delete();
        req(nexus_pkg::FN_IL_WRITE, 28'h2, 4'hf, 32'ha5a5a5a5, 0);
        repeat (20) @(posedge CLK_I);
        chk({RSP_STATUS_O, PAUSE_HELD_O, wq[0]}, {3'h2, 28'h2, 4'hf, 32'ha5a5a5a5});
        req(nexus_pkg::FN_IL_READ, 28'h2, 4'hf, 0, 0);
        repeat (3950) @(posedge CLK_I);
        chk(PAUSE_HELD_O, 1);
        repeat (150) @(posedge CLK_I);
        chk(PAUSE_HELD_O, 0);
        req(nexus_pkg::FN_IL_WRITE, 28'h2, 4'hf, 32'h5a5a5a5a, 0);
        // warning rises after the address word, so only the data return is lost
        fork
            req(nexus_pkg::FN_READ, 28'h2, 4'hf, 0, 0);
            begin
                repeat (9) @(posedge CLK_I);
                L.clock_loss <= 1;
            end
        join
        chk(RSP_STATUS_O, 2);
        L.clock_loss <= 0;
        RESTORE_I <= 1;
        @(posedge CLK_I) RESTORE_I <= 0;
        repeat (120) @(posedge CLK_I);
        chk(RESTORE_O, 1);
        req(nexus_pkg::FN_READ, 28'h2, 4'hf, 0, 0);
        chk({RSP_STATUS_O, RSP_DATA_O}, {2'h1, 32'h5a5a5a5a});
        AC_LOW_I <= 1;
        repeat (8) @(posedge CLK_I);
        chk(L.fail, 1);
        AC_LOW_I <= 0;
        repeat (8) @(posedge CLK_I);
        chk(L.fail, 0);
        test_done();
    end
    initial begin
        #300us;
        fails++;
        test_done();
    end
endmodule : tb
`default_nettype wire
